// ==== src/nor_cmd_pkg.sv ====
// Shared types and constants of the serial NOR flash command decoder.
package nor_cmd_pkg;

  // --------------------------------------------------------------------
  // Protocols, directions and decoder states
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    PROTO_EXT  = 2'h0,
    PROTO_DUAL = 2'h1,
    PROTO_QUAD = 2'h2
  } proto_e;

  typedef enum logic [1:0] {
    DIR_NONE = 2'h0,
    DIR_IN   = 2'h1,
    DIR_OUT  = 2'h2
  } dir_e;

  typedef enum logic [2:0] {
    ST_OPC    = 3'h0,
    ST_ADDR   = 3'h1,
    ST_DUMMY  = 3'h3,
    ST_DATA   = 3'h2,
    ST_IGNORE = 3'h6
  } state_e;

  typedef logic [2:0] lanes_t;

  localparam lanes_t LANES_0 = 3'h0;
  localparam lanes_t LANES_1 = 3'h1;
  localparam lanes_t LANES_2 = 3'h2;
  localparam lanes_t LANES_4 = 3'h4;

  // --------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    lanes_t     addr_w;
    lanes_t     data_w;
    logic [2:0] abytes;
    logic [4:0] dummy;
    dir_e       dir;
    logic       dtr;
    logic       fixed_dummy;
    logic       gp;
    logic       disc;
  } cmd_info_s;

  // Flags field order: dtr, fixed dummy, general purpose, discovery.
  typedef struct packed {
    lanes_t     aw;
    lanes_t     dw;
    logic [1:0] ok;
    logic [2:0] ab;
    logic [4:0] de;
    logic [4:0] dq;
    dir_e       dir;
    logic [3:0] flags;
  } table_row_s;

  typedef struct packed {
    logic       cs_n;
    logic       sclk;
    logic [3:0] lanes;
  } link_s;

  // --------------------------------------------------------------------
  // Opcodes
  // --------------------------------------------------------------------
  localparam logic [7:0] OP_DISC_READ  = 8'h5A;
  localparam logic [7:0] OP_ID_READ_A  = 8'h9E;
  localparam logic [7:0] OP_ID_READ_B  = 8'h9F;
  localparam logic [7:0] OP_ID_READ_MIO = 8'hAF;
  localparam logic [7:0] OP_QIO_READ   = 8'hEB;
  localparam logic [7:0] OP_QIO_DTR    = 8'hED;
  localparam logic [7:0] OP_DIO_READ   = 8'hBB;
  localparam logic [7:0] OP_DIO_DTR    = 8'hBD;
  localparam logic [7:0] OP_QO_READ    = 8'h6B;
  localparam logic [7:0] OP_QO_DTR     = 8'h6D;
  localparam logic [7:0] OP_DO_READ    = 8'h3B;
  localparam logic [7:0] OP_DO_DTR     = 8'h3D;
  localparam logic [7:0] OP_FLAG_READ  = 8'h70;
  localparam logic [7:0] OP_VCFG_READ  = 8'h85;
  localparam logic [7:0] OP_EVCFG_READ = 8'h65;
  localparam logic [7:0] OP_GP_READ    = 8'h96;
  localparam logic [7:0] OP_EVCFG_WR   = 8'h61;
  localparam logic [7:0] OP_FLAG_CLR   = 8'h50;
  localparam logic [7:0] OP_DI_PROG    = 8'hA2;
  localparam logic [7:0] OP_EDI_PROG   = 8'hD2;
  localparam logic [7:0] OP_QI_PROG    = 8'h32;
  localparam logic [7:0] OP_EQI_PROG   = 8'h38;

  // --------------------------------------------------------------------
  // Counts and reset values
  // --------------------------------------------------------------------
  localparam logic [2:0] ADDR_BYTES  = 3'h3;
  localparam logic [4:0] DUMMY_0     = 5'h00;
  localparam logic [4:0] DUMMY_6     = 5'h06;
  localparam logic [4:0] DUMMY_8     = 5'h08;
  localparam logic [4:0] DUMMY_10    = 5'h0A;
  localparam logic [6:0] GP_BYTES    = 7'h40;
  localparam logic [7:0] GP_FILL     = 8'h00;
  localparam logic [5:0] LINK_RESET  = 6'h20;
  localparam logic [3:0] LANES_IDLE  = 4'h0;
  localparam logic [3:0] OE_1        = 4'h2;
  localparam logic [3:0] OE_2        = 4'h3;
  localparam logic [3:0] OE_4        = 4'hF;

endpackage

// ==== src/bit_sync.sv ====
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/1ns
module bit_sync #(
  parameter int               WIDTH   = 6,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= RST_VAL;
      q_o  <= RST_VAL;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule // bit_sync

// ==== src/cmd_table.sv ====
// Opcode table: lane widths, address bytes and dummy clocks per protocol.
`timescale 1ns/1ns
module cmd_table (
  input  wire logic [7:0]               opcode_i,
  input  nor_cmd_pkg::proto_e           proto_i,
  output nor_cmd_pkg::cmd_info_s        info_o
);

  localparam nor_cmd_pkg::lanes_t W0 = nor_cmd_pkg::LANES_0;
  localparam nor_cmd_pkg::lanes_t W1 = nor_cmd_pkg::LANES_1;
  localparam nor_cmd_pkg::lanes_t W2 = nor_cmd_pkg::LANES_2;
  localparam nor_cmd_pkg::lanes_t W4 = nor_cmd_pkg::LANES_4;
  localparam logic [2:0] A3  = nor_cmd_pkg::ADDR_BYTES;
  localparam logic [2:0] A0  = 3'h0;
  localparam logic [4:0] D0  = nor_cmd_pkg::DUMMY_0;
  localparam logic [4:0] D6  = nor_cmd_pkg::DUMMY_6;
  localparam logic [4:0] D8  = nor_cmd_pkg::DUMMY_8;
  localparam logic [4:0] D10 = nor_cmd_pkg::DUMMY_10;
  localparam nor_cmd_pkg::dir_e RD = nor_cmd_pkg::DIR_OUT;
  localparam nor_cmd_pkg::dir_e WR = nor_cmd_pkg::DIR_IN;
  localparam nor_cmd_pkg::dir_e NO = nor_cmd_pkg::DIR_NONE;

  nor_cmd_pkg::table_row_s row;
  nor_cmd_pkg::lanes_t     multi_w;

  // Row fields: address lanes, data lanes, {dual ok, quad ok}, address bytes,
  // dummy in extended and dual, dummy in quad, direction, flags.
  always_comb begin
    case (opcode_i)
      nor_cmd_pkg::OP_DISC_READ:   row = '{W1, W1, 2'h3, A3, D8, D8, RD, 4'h1};
      nor_cmd_pkg::OP_ID_READ_A,
      nor_cmd_pkg::OP_ID_READ_B:   row = '{W0, W1, 2'h0, A0, D0, D0, RD, 4'h0};
      nor_cmd_pkg::OP_ID_READ_MIO: row = '{W0, W1, 2'h3, A0, D0, D0, RD, 4'h0};
      nor_cmd_pkg::OP_QIO_READ:    row = '{W4, W4, 2'h1, A3, D10, D10, RD, 4'h0};
      nor_cmd_pkg::OP_QIO_DTR:     row = '{W4, W4, 2'h1, A3, D8, D8, RD, 4'h8};
      nor_cmd_pkg::OP_DIO_READ:    row = '{W2, W2, 2'h2, A3, D8, D8, RD, 4'h0};
      nor_cmd_pkg::OP_DIO_DTR:     row = '{W2, W2, 2'h2, A3, D6, D6, RD, 4'h8};
      nor_cmd_pkg::OP_QO_READ:     row = '{W1, W4, 2'h1, A3, D8, D10, RD, 4'h0};
      nor_cmd_pkg::OP_QO_DTR:      row = '{W1, W4, 2'h1, A3, D6, D8, RD, 4'h8};
      nor_cmd_pkg::OP_DO_READ:     row = '{W1, W2, 2'h2, A3, D8, D8, RD, 4'h0};
      nor_cmd_pkg::OP_DO_DTR:      row = '{W1, W2, 2'h2, A3, D6, D6, RD, 4'h8};
      nor_cmd_pkg::OP_FLAG_READ:   row = '{W0, W1, 2'h3, A0, D0, D0, RD, 4'h0};
      nor_cmd_pkg::OP_VCFG_READ:   row = '{W0, W1, 2'h3, A0, D0, D0, RD, 4'h0};
      nor_cmd_pkg::OP_EVCFG_READ:  row = '{W0, W1, 2'h3, A0, D0, D0, RD, 4'h0};
      nor_cmd_pkg::OP_GP_READ:     row = '{W0, W1, 2'h3, A0, D8, D8, RD, 4'h6};
      nor_cmd_pkg::OP_EVCFG_WR:    row = '{W0, W1, 2'h3, A0, D0, D0, WR, 4'h0};
      nor_cmd_pkg::OP_FLAG_CLR:    row = '{W0, W0, 2'h3, A0, D0, D0, NO, 4'h0};
      nor_cmd_pkg::OP_DI_PROG:     row = '{W1, W2, 2'h2, A3, D0, D0, WR, 4'h0};
      nor_cmd_pkg::OP_EDI_PROG:    row = '{W2, W2, 2'h2, A3, D0, D0, WR, 4'h0};
      nor_cmd_pkg::OP_QI_PROG:     row = '{W1, W4, 2'h1, A3, D0, D0, WR, 4'h0};
      nor_cmd_pkg::OP_EQI_PROG:    row = '{W4, W4, 2'h1, A3, D0, D0, WR, 4'h0};
      default:                     row = '{W0, W0, 2'h0, A0, D0, D0, NO, 4'h0};
    endcase
  end

  // In dual and quad protocol every phase that exists runs on all lanes.
  always_comb begin
    multi_w            = (proto_i == nor_cmd_pkg::PROTO_QUAD) ? W4 : W2;
    info_o.abytes      = row.ab;
    info_o.dir         = row.dir;
    info_o.dtr         = row.flags[3];
    info_o.fixed_dummy = row.flags[2];
    info_o.gp          = row.flags[1];
    info_o.disc        = row.flags[0];
    case (proto_i)
      nor_cmd_pkg::PROTO_EXT: begin
        info_o.valid  = (row.dir != NO) || (row.ok != 2'h0);
        info_o.addr_w = row.aw;
        info_o.data_w = row.dw;
        info_o.dummy  = row.de;
      end
      nor_cmd_pkg::PROTO_DUAL: begin
        info_o.valid  = row.ok[1];
        info_o.addr_w = (row.ab != A0) ? multi_w : W0;
        info_o.data_w = (row.dir != NO) ? multi_w : W0;
        info_o.dummy  = row.de;
      end
      nor_cmd_pkg::PROTO_QUAD: begin
        info_o.valid  = row.ok[0];
        info_o.addr_w = (row.ab != A0) ? multi_w : W0;
        info_o.data_w = (row.dir != NO) ? multi_w : W0;
        info_o.dummy  = row.dq;
      end
      default: begin
        info_o.valid  = 1'b0;
        info_o.addr_w = W0;
        info_o.data_w = W0;
        info_o.dummy  = D0;
      end
    endcase
  end

endmodule // cmd_table

// ==== src/nor_flash_command_decoder.sv ====
// Command decoder of a multiple-lane serial NOR flash, on the system clock.
// Notes on behaviour
// - Discovery read 5Ah: three address, eight dummy.
// - Discovery tables answer only the discovery read.
// - ID reads: 9E/9Fh extended only, AFh everywhere.
// - EBh quad I/O read, ten dummy, not dual.
// - EDh DTR quad I/O read, eight dummy.
// - BBh dual I/O read, eight dummy, not quad.
// - BDh DTR dual I/O read, six dummy.
// - 6Bh quad output read, eight or ten dummy.
// - 6Dh DTR quad output read, six or eight.
// - 3Bh dual output read, eight dummy.
// - 3Dh DTR dual output read, six dummy.
// - 70h flag read, data on protocol lanes.
// - 85h configuration read, no address, no dummy.
// - 65h enhanced configuration read, no dummy.
// - 96h general register read, eight dummy always.
// - 61h write: data directly after opcode.
// - 50h flag clear: opcode alone, no data.
// - A2h dual input program, three address bytes.
// - D2h extended dual input program, no dummy.
// - 32h quad input program, not in dual.
// - 38h extended quad input program, no dummy.
// - Opcode rides one, two or four lanes.
// - Dummy count comes from nonzero configuration, except 96h and commands without dummy.
// - General register: 64 bytes, then zeros, no wrap.
`timescale 1ns/1ns
module nor_flash_command_decoder (
  input  wire logic                   clk_sys_i,
  input  wire logic                   rstn_i,
  input  wire logic                   sclk_i,
  input  wire logic                   cs_n_i,
  input  wire logic [3:0]             serial_data_lanes_i,
  input  nor_cmd_pkg::proto_e         proto_i,
  input  wire logic [4:0]             dummy_cfg_i,
  input  wire logic [7:0]             rd_data_i,
  output logic      [3:0]             serial_data_lanes_o,
  output logic      [3:0]             serial_data_lanes_oe_o,
  output logic                        cmd_valid_o,
  output logic      [7:0]             cmd_opcode_o,
  output nor_cmd_pkg::cmd_info_s      cmd_info_o,
  output logic                        addr_valid_o,
  output logic      [23:0]            addr_o,
  output logic                        wr_valid_o,
  output logic      [7:0]             wr_data_o,
  output logic                        rd_req_o,
  output logic                        disc_sel_o,
  output logic                        ignored_o,
  output logic                        cmd_end_o
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic logic [7:0] shift_in(input logic [7:0] s, input logic [3:0] d,
                                          input nor_cmd_pkg::lanes_t w);
    case (w)
      nor_cmd_pkg::LANES_4: shift_in = {s[3:0], d};
      nor_cmd_pkg::LANES_2: shift_in = {s[5:0], d[1:0]};
      default:              shift_in = {s[6:0], d[0]};
    endcase
  endfunction

  function automatic logic [4:0] beats(input nor_cmd_pkg::lanes_t w);
    case (w)
      nor_cmd_pkg::LANES_4: beats = 5'h02;
      nor_cmd_pkg::LANES_2: beats = 5'h04;
      default:              beats = 5'h08;
    endcase
  endfunction

  // --------------------------------------------------------------------
  // Pin synchronisation and edge finding
  // --------------------------------------------------------------------
  nor_cmd_pkg::link_s link_raw;
  nor_cmd_pkg::link_s link;
  logic               sclk_q;
  logic               cs_q;
  logic               rise;
  logic               fall;
  logic               cs_high;

  assign link_raw.cs_n  = cs_n_i;
  assign link_raw.sclk  = sclk_i;
  assign link_raw.lanes = serial_data_lanes_i;

  bit_sync #(
    .WIDTH   (6),
    .RST_VAL (nor_cmd_pkg::LINK_RESET)
  ) u_sync (
    .clk_i  (clk_sys_i),
    .rstn_i (rstn_i),
    .d_i    (link_raw),
    .q_o    (link)
  );

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sclk_q <= 1'b0;
      cs_q   <= 1'b1;
    end else begin
      sclk_q <= link.sclk;
      cs_q   <= link.cs_n;
    end
  end

  assign rise    = link.sclk & ~sclk_q;
  assign fall    = ~link.sclk & sclk_q;
  assign cs_high = link.cs_n;

  // --------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------
  nor_cmd_pkg::state_e    state;
  nor_cmd_pkg::cmd_info_s cmd;
  nor_cmd_pkg::cmd_info_s tbl;
  nor_cmd_pkg::lanes_t    proto_w;
  nor_cmd_pkg::lanes_t    pw;
  logic [4:0]             beat;
  logic [4:0]             dcnt;
  logic [4:0]             dum_sel;
  logic [4:0]             abeats;
  logic [7:0]             sh;
  logic [7:0]             opc_next;
  logic                   samp;
  logic                   opc_done;
  logic                   addr_last;
  logic                   in_last;

  always_comb begin
    case (proto_i)
      nor_cmd_pkg::PROTO_QUAD: proto_w = nor_cmd_pkg::LANES_4;
      nor_cmd_pkg::PROTO_DUAL: proto_w = nor_cmd_pkg::LANES_2;
      default:                 proto_w = nor_cmd_pkg::LANES_1;
    endcase
  end

  always_comb begin
    case (state)
      nor_cmd_pkg::ST_OPC:  pw = proto_w;
      nor_cmd_pkg::ST_ADDR: pw = cmd.addr_w;
      default:              pw = cmd.data_w;
    endcase
  end

  // Double transfer rate moves address and data on both clock edges.
  assign samp      = (state == nor_cmd_pkg::ST_OPC) ? rise : (rise | (cmd.dtr & fall));
  assign opc_next  = shift_in(sh, link.lanes, proto_w);
  assign opc_done  = rise && (beat == beats(proto_w) - 5'h01);
  assign abeats    = 5'(cmd.abytes * beats(cmd.addr_w));
  assign addr_last = samp && (beat == abeats - 5'h01);
  assign in_last   = samp && (beat == beats(cmd.data_w) - 5'h01);

  cmd_table u_table (
    .opcode_i (opc_next),
    .proto_i  (proto_i),
    .info_o   (tbl)
  );

  // A configured count of zero keeps the default of the command.
  always_comb begin
    if (tbl.fixed_dummy || tbl.dummy == nor_cmd_pkg::DUMMY_0 ||
        dummy_cfg_i == nor_cmd_pkg::DUMMY_0) begin
      dum_sel = tbl.dummy;
    end else begin
      dum_sel = dummy_cfg_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= nor_cmd_pkg::ST_OPC;
      beat  <= 5'h00;
      dcnt  <= 5'h00;
      sh    <= 8'h00;
      cmd   <= '0;
    end else if (cs_high) begin
      state <= nor_cmd_pkg::ST_OPC;
      beat  <= 5'h00;
      sh    <= 8'h00;
    end else begin
      case (state)
        nor_cmd_pkg::ST_OPC: begin
          if (rise) begin
            sh <= opc_next;
            if (opc_done) begin
              beat <= 5'h00;
              cmd  <= tbl;
              dcnt <= dum_sel;
              if (!tbl.valid) begin
                state <= nor_cmd_pkg::ST_IGNORE;
              end else if (tbl.abytes != 3'h0) begin
                state <= nor_cmd_pkg::ST_ADDR;
              end else if (dum_sel != nor_cmd_pkg::DUMMY_0) begin
                state <= nor_cmd_pkg::ST_DUMMY;
              end else begin
                state <= nor_cmd_pkg::ST_DATA;
              end
            end else begin
              beat <= beat + 5'h01;
            end
          end
        end
        nor_cmd_pkg::ST_ADDR: begin
          if (addr_last) begin
            beat  <= 5'h00;
            state <= (dcnt != nor_cmd_pkg::DUMMY_0) ? nor_cmd_pkg::ST_DUMMY
                                                   : nor_cmd_pkg::ST_DATA;
          end else if (samp) begin
            beat <= beat + 5'h01;
          end
        end
        nor_cmd_pkg::ST_DUMMY: begin
          if (rise) begin
            dcnt <= dcnt - 5'h01;
            if (dcnt == 5'h01) begin
              state <= nor_cmd_pkg::ST_DATA;
            end
          end
        end
        nor_cmd_pkg::ST_DATA: begin
          if (samp && cmd.dir == nor_cmd_pkg::DIR_IN) begin
            sh   <= shift_in(sh, link.lanes, pw);
            beat <= in_last ? 5'h00 : beat + 5'h01;
          end
        end
        nor_cmd_pkg::ST_IGNORE: begin
          beat <= 5'h00;
        end
        default: begin
          state <= nor_cmd_pkg::ST_IGNORE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Address capture
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      addr_o       <= 24'h000000;
      addr_valid_o <= 1'b0;
    end else begin
      addr_valid_o <= 1'b0;
      if (!cs_high && state == nor_cmd_pkg::ST_ADDR && samp) begin
        case (cmd.addr_w)
          nor_cmd_pkg::LANES_4: addr_o <= {addr_o[19:0], link.lanes};
          nor_cmd_pkg::LANES_2: addr_o <= {addr_o[21:0], link.lanes[1:0]};
          default:              addr_o <= {addr_o[22:0], link.lanes[0]};
        endcase
        addr_valid_o <= addr_last;
      end
    end
  end

  // --------------------------------------------------------------------
  // Command report and write data
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmd_valid_o  <= 1'b0;
      ignored_o    <= 1'b0;
      cmd_end_o    <= 1'b0;
      cmd_opcode_o <= 8'h00;
      cmd_info_o   <= '0;
      wr_valid_o   <= 1'b0;
      wr_data_o    <= 8'h00;
      disc_sel_o   <= 1'b0;
    end else begin
      cmd_valid_o <= 1'b0;
      ignored_o   <= 1'b0;
      wr_valid_o  <= 1'b0;
      cmd_end_o   <= link.cs_n & ~cs_q;
      if (!cs_high && state == nor_cmd_pkg::ST_OPC && opc_done) begin
        cmd_opcode_o <= opc_next;
        cmd_info_o   <= tbl;
        cmd_valid_o  <= tbl.valid;
        ignored_o    <= ~tbl.valid;
      end
      if (!cs_high && state == nor_cmd_pkg::ST_DATA &&
          cmd.dir == nor_cmd_pkg::DIR_IN && in_last) begin
        wr_valid_o <= 1'b1;
        wr_data_o  <= shift_in(sh, link.lanes, cmd.data_w);
      end
      // The table source is selected only while a discovery read streams.
      disc_sel_o <= !cs_high && state == nor_cmd_pkg::ST_DATA && cmd.disc;
    end
  end

  // --------------------------------------------------------------------
  // Read data output
  // --------------------------------------------------------------------
  // A byte is fetched as soon as the last one has left, so the source must
  // answer in the same cycle as the request; a late source underruns.
  logic       out_act;
  logic       drive;
  logic       out_full;
  logic [7:0] out_sh;
  logic [4:0] out_cnt;
  logic [6:0] gp_cnt;

  assign out_act = !cs_high && state == nor_cmd_pkg::ST_DATA &&
                   cmd.dir == nor_cmd_pkg::DIR_OUT;
  assign drive   = fall | (cmd.dtr & rise);

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_sh                 <= 8'h00;
      out_full               <= 1'b0;
      out_cnt                <= 5'h00;
      gp_cnt                 <= 7'h00;
      rd_req_o               <= 1'b0;
      serial_data_lanes_o    <= nor_cmd_pkg::LANES_IDLE;
      serial_data_lanes_oe_o <= nor_cmd_pkg::LANES_IDLE;
    end else if (!out_act) begin
      out_full               <= 1'b0;
      gp_cnt                 <= 7'h00;
      rd_req_o               <= 1'b0;
      serial_data_lanes_o    <= nor_cmd_pkg::LANES_IDLE;
      serial_data_lanes_oe_o <= nor_cmd_pkg::LANES_IDLE;
    end else begin
      rd_req_o <= 1'b0;
      if (!out_full && !rd_req_o) begin
        if (cmd.gp && gp_cnt == nor_cmd_pkg::GP_BYTES) begin
          out_sh   <= nor_cmd_pkg::GP_FILL;
          out_full <= 1'b1;
          out_cnt  <= beats(cmd.data_w);
        end else begin
          rd_req_o <= 1'b1;
        end
      end
      if (rd_req_o) begin
        out_sh   <= rd_data_i;
        out_full <= 1'b1;
        out_cnt  <= beats(cmd.data_w);
        gp_cnt   <= gp_cnt + 7'h01;
      end
      if (drive && out_full) begin
        out_cnt  <= out_cnt - 5'h01;
        out_full <= (out_cnt != 5'h01);
        case (cmd.data_w)
          nor_cmd_pkg::LANES_4: begin
            serial_data_lanes_o    <= out_sh[7:4];
            serial_data_lanes_oe_o <= nor_cmd_pkg::OE_4;
            out_sh                 <= {out_sh[3:0], 4'h0};
          end
          nor_cmd_pkg::LANES_2: begin
            serial_data_lanes_o    <= {2'h0, out_sh[7:6]};
            serial_data_lanes_oe_o <= nor_cmd_pkg::OE_2;
            out_sh                 <= {out_sh[5:0], 2'h0};
          end
          default: begin
            serial_data_lanes_o    <= {2'h0, out_sh[7], 1'b0};
            serial_data_lanes_oe_o <= nor_cmd_pkg::OE_1;
            out_sh                 <= {out_sh[6:0], 1'b0};
          end
        endcase
      end
    end
  end

endmodule // nor_flash_command_decoder

// ==== sim/nor_decoder_props.sv ====
// Port assertions for the serial NOR command decoder.
`timescale 1ns/1ns
module nor_decoder_props (
  input wire logic              clk_sys_i,
  input wire logic              rstn_i,
  input wire logic              cs_n_i,
  input nor_cmd_pkg::proto_e    proto_i,
  input wire logic [3:0]        serial_data_lanes_oe_o,
  input wire logic              cmd_valid_o,
  input wire logic [7:0]        cmd_opcode_o,
  input nor_cmd_pkg::cmd_info_s cmd_info_o,
  input wire logic              rd_req_o,
  input wire logic              disc_sel_o,
  input wire logic              ignored_o,
  input wire logic              cmd_end_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  sequence s_quiet;
    serial_data_lanes_oe_o == 4'h0 [*8];
  endsequence
  a_ignore_quiet: assert property (ignored_o |=> s_quiet)
    else $error("lanes driven after ignore");
  a_verdict_once: assert property (cmd_valid_o |-> !ignored_o ##1 !cmd_valid_o)
    else $error("double decode verdict");
  a_disc_only: assert property (disc_sel_o |->
    cmd_opcode_o == nor_cmd_pkg::OP_DISC_READ && cmd_info_o.dummy == nor_cmd_pkg::DUMMY_8)
    else $error("discovery data outside its command");
  a_rd_spaced: assert property (rd_req_o |=> !rd_req_o [*4])
    else $error("read requests too close");
  a_end_sync: assert property ($rose(cs_n_i) |-> ##[1:6] cmd_end_o)
    else $error("deselect not seen");
  a_ext_id: assert property (cmd_valid_o && proto_i != nor_cmd_pkg::PROTO_EXT |->
    !(cmd_opcode_o inside {8'h9E, 8'h9F})) else $error("id read outside extended");
  a_dual_lanes: assert property (cmd_valid_o && proto_i == nor_cmd_pkg::PROTO_DUAL |->
    cmd_info_o.data_w != nor_cmd_pkg::LANES_4) else $error("quad data in dual");
  a_gp_fixed: assert property (cmd_valid_o && cmd_opcode_o == 8'h96 |->
    cmd_info_o.dummy == nor_cmd_pkg::DUMMY_8 && cmd_info_o.fixed_dummy)
    else $error("general register dummy wrong");
endmodule // nor_decoder_props
bind nor_flash_command_decoder nor_decoder_props i_nor_decoder_props (.clk_sys_i, .rstn_i,
  .cs_n_i, .proto_i, .serial_data_lanes_oe_o, .cmd_valid_o, .cmd_opcode_o, .cmd_info_o,
  .rd_req_o, .disc_sel_o, .ignored_o, .cmd_end_o);

// ==== sim/spi_host.sv ====
// Host controller model that frames opcodes on the serial link.
`timescale 1ns/1ns
module spi_host (
  output logic       sclk_o,
  output logic       cs_n_o,
  output logic [3:0] lanes_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    lanes_o = 4'h0;
  end
  // Lanes change only while the clock is low; after the opcode they toggle as noise.
  task automatic frame(input logic [7:0] op, input int w, input int n);
    logic [7:0] sh;
    sh = op;
    #5 cs_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      lanes_o = (i < 8 / w) ? 4'(sh >> (8 - w)) : ~lanes_o;
      sh = sh << w;
      #32 sclk_o = 1'b1;
      #32 sclk_o = 1'b0;
    end
    #32 cs_n_o = 1'b1;
    lanes_o = ~lanes_o;
  endtask
endmodule // spi_host

// ==== sim/nor_flash_command_decoder_bench.sv ====
// Self-checking bench for the serial NOR command decoder.
`timescale 1ns/1ns
module nor_flash_command_decoder_bench;
  logic                   clk_sys_i = 1'b0;
  logic                   rstn_i = 1'b0;
  logic                   sclk_i, cs_n_i, cmd_valid_o, ignored_o, addr_valid_o, cs_d;
  logic [3:0]             host_d, serial_data_lanes_o, serial_data_lanes_oe_o;
  logic [4:0]             dummy_cfg = 5'h00;
  logic [7:0]             rd_data_i = 8'h00;
  logic [23:0]            addr_o;
  logic [38:0]            got;
  nor_cmd_pkg::proto_e    proto_i = nor_cmd_pkg::PROTO_EXT;
  nor_cmd_pkg::cmd_info_s cmd_info_o;
  int                     num_errors = 0;
  int                     tests_run = 0;
  localparam logic [38:0] NA = 39'h4000;
  // Opcode, protocol mask, address and data lanes (F = protocol width), dummy ext/dual, quad.
  localparam logic [27:0] T [22] = '{28'h5A7FF88, 28'h9E10100, 28'h9F10100,
    28'hAF70F00, 28'hEB544AA, 28'hED54488, 28'hBB32288, 28'hBD32266,
    28'h6B5F48A, 28'h6D5F468, 28'h3B3F288, 28'h3D3F266, 28'h7070F00,
    28'h8570F00, 28'h6570F00, 28'h9670F88, 28'h6170F00, 28'h5070000,
    28'hA23F200, 28'hD232200, 28'h325F400, 28'h3854400};
  wire [3:0] lanes = (serial_data_lanes_oe_o & serial_data_lanes_o) |
                     (~serial_data_lanes_oe_o & host_d);
  always #4 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) #1 rd_data_i = 8'($urandom);
  spi_host i_spi_host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .lanes_o(host_d));
  nor_flash_command_decoder i_nor_flash_command_decoder (.clk_sys_i, .rstn_i, .sclk_i, .cs_n_i,
    .serial_data_lanes_i(lanes), .proto_i, .dummy_cfg_i(dummy_cfg), .rd_data_i,
    .serial_data_lanes_o, .serial_data_lanes_oe_o, .cmd_valid_o, .cmd_opcode_o(), .cmd_info_o,
    .addr_valid_o, .addr_o, .wr_valid_o(), .wr_data_o(), .rd_req_o(), .disc_sel_o(), .ignored_o,
    .cmd_end_o());
  always @(posedge clk_sys_i) begin
    cs_d <= cs_n_i;
    if (cs_d === 1'b1 && cs_n_i === 1'b0) got <= '0;
    if (cmd_valid_o === 1'b1) got[13:0] <= {cmd_info_o.addr_w, cmd_info_o.data_w,
      cmd_info_o.abytes, cmd_info_o.dummy};
    if (ignored_o === 1'b1) got[14] <= 1'b1;
    if (addr_valid_o === 1'b1) got[38:15] <= addr_o;
  end
  // The host toggles all lanes after the opcode, so the address is that pattern;
  // double-rate commands take each beat twice, on the fall and then the rise.
  function automatic logic [38:0] e(logic [7:0] o, int p);
    logic [3:0] a, d, v;
    e = NA;
    foreach (T[i]) begin
      if (T[i][27:20] == o && T[i][16 + p]) begin
        a = T[i][15:12] == 4'hF ? 4'(1 << p) : T[i][15:12];
        d = T[i][11:8] == 4'hF ? 4'(1 << p) : T[i][11:8];
        e[14:0] = {1'b0, a[2:0], d[2:0], a != 4'h0 ? 3'h3 : 3'h0,
                   1'b0, p == 2 ? T[i][3:0] : T[i][7:4]};
        v = 4'(o & ((1 << (1 << p)) - 1));
        for (int j = 0; a != 4'h0 && j < 24 / a; j++) begin
          if (j % 2 == 0 || !(o inside {8'hED, 8'hBD, 8'h6D, 8'h3D})) v = ~v;
          e[38:15] = 24'((e[38:15] << a) | (v & ((1 << a) - 1)));
        end
      end
    end
  endfunction
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    logic [7:0] op;
    void'($urandom(32'h6699A90C));
    repeat (4) @(posedge clk_sys_i);
    #1 rstn_i = 1'b1;
    for (int p = 0; p < 3; p++) begin
      for (int k = 0; k < 26; k++) begin
        op = k < 22 ? T[k][27:20] : 8'($urandom);
        @(posedge clk_sys_i);
        #1 proto_i = nor_cmd_pkg::proto_e'(p);
        dummy_cfg = 5'($urandom);
        i_spi_host.frame(op, 1 << p, 48);
        repeat (8) @(posedge clk_sys_i);
        tests_run++;
        if (got !== e(op, p)) begin
          num_errors++;
          $display("BAD %0t op %h proto %0d got %h", $time, op, p, got);
        end
      end
    end
    end_sim();
  end
  initial begin
    #400000;
    num_errors++;
    end_sim();
  end
endmodule // nor_flash_command_decoder_bench
